// ==== hw/qrb_cfg.svh ====
`ifndef QRB_CFG_SVH
`define QRB_CFG_SVH

// =====================================================================
// widths and reset values
`define QRB_LANES      4
`define QRB_OUT_RESET  4'h0
`define QRB_HELD_RESET 4'h0
`define QRB_LCLK_RESET 1'h1

`endif

// ==== hw/qrb_pkg.sv ====
`include "qrb_cfg.svh"

package qrb_pkg;

  // =====================================================================
  // types
  typedef logic [`QRB_LANES-1:0] qrb_lanes_t;

  typedef enum logic [1:0] {
    QRB_OFF,
    QRB_ASYNC,
    QRB_SYNC
  } qrb_mode_t;

  // =====================================================================
  // mode decode from enable and select levels
  function automatic qrb_mode_t qrb_decode(input logic en, input logic sel);
    qrb_mode_t m;
    m = QRB_OFF;
    if (en) begin
      m = sel ? QRB_ASYNC : QRB_SYNC;
    end
    return m;
  endfunction

endpackage

// ==== hw/qrb_lane_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// capture strobe, lane data and held values between control and store
interface qrb_lane_if;
  import qrb_pkg::*;
  logic       capture;
  qrb_lanes_t din;
  qrb_lanes_t held;

  modport ctrl  (output capture, output din, input held);
  modport store (input capture, input din, output held);
endinterface

`default_nettype wire

// ==== hw/qrb_hold.sv ====
`timescale 1ns/1ps
`default_nettype none

`include "qrb_cfg.svh"

module qrb_hold
  import qrb_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      reset_i,
  qrb_lane_if.store      lane_if
);

  localparam qrb_lanes_t HELD_RST = `QRB_HELD_RESET;

  wire logic [`QRB_LANES-1:0] held_w;

  // =====================================================================
  // one capture flop per lane, all sharing one strobe
  genvar i;
  generate
    for (i = 0; i < `QRB_LANES; i++) begin : g_lane
      logic bit_reg;
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          bit_reg <= HELD_RST[i];
        end else if (lane_if.capture) begin
          bit_reg <= lane_if.din[i];
        end
      end
      assign held_w[i] = bit_reg;
    end
  endgenerate

  assign lane_if.held = held_w;

endmodule // qrb_hold

`default_nettype wire

// ==== hw/qrb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

`include "qrb_cfg.svh"

module qrb_top
  import qrb_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       enable_i,
  input  wire logic       async_sel_i,
  input  wire logic       lane_clk_i,
  input  wire qrb_lanes_t lane_data_i,
  output var  qrb_lanes_t lane_out_o
);

  localparam qrb_lanes_t OUT_RST = `QRB_OUT_RESET;

  qrb_lane_if lane_if ();

  qrb_mode_t  mode;
  logic       lclk_prev_reg;
  logic       lclk_rise;
  logic       lclk_fall;
  qrb_lanes_t out_reg;
  qrb_lanes_t out_next;

  // =====================================================================
  // mode decode and lane clock edge detect (each pin is one bit)
  // the lane clock is a plain input sampled on clk_i, so an edge is a change
  // between two samples; it must stay high and low for a cycle each
  assign mode      = qrb_decode(enable_i, async_sel_i);
  assign lclk_rise = lane_clk_i & ~lclk_prev_reg;
  assign lclk_fall = ~lane_clk_i & lclk_prev_reg;

  // capture only on a rising edge in synchronous mode while enabled
  assign lane_if.capture = (mode == QRB_SYNC) && lclk_rise;
  assign lane_if.din     = lane_data_i;

  // =====================================================================
  // lane clock history; tracked always so no stale edge after re-enable
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      lclk_prev_reg <= `QRB_LCLK_RESET;
    end else begin
      lclk_prev_reg <= lane_clk_i;
    end
  end

  // =====================================================================
  // capture store
  qrb_hold u_hold (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .lane_if (lane_if)
  );

  // =====================================================================
  // output select per mode
  always_comb begin
    case (mode)
      QRB_OFF: begin
        out_next = '0;
      end
      QRB_ASYNC: begin
        out_next = lane_data_i;
      end
      QRB_SYNC: begin
        out_next = lane_if.capture ? lane_data_i : lane_if.held;
      end
      default: begin
        out_next = '0;
      end
    endcase
  end

  // output register; both paths pass through it, so every mode answers
  // one clk_i cycle after the inputs are sampled and the pins never glitch
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      out_reg <= OUT_RST;
    end else begin
      out_reg <= out_next;
    end
  end

  assign lane_out_o = out_reg;

  // =====================================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // synchronous mode with a rising lane clock this cycle
  sequence sync_rise_s;
    enable_i && !async_sel_i && lane_clk_i && !lclk_prev_reg;
  endsequence

  // synchronous mode with a falling lane clock this cycle
  sequence sync_fall_s;
    enable_i && !async_sel_i && lclk_fall;
  endsequence

  // synchronous mode with no rising lane clock this cycle
  sequence sync_quiet_s;
    enable_i && !async_sel_i && !lclk_rise;
  endsequence

  // synchronous mode with the lane clock already high on the last sample
  sequence sync_level_s;
    enable_i && !async_sel_i && lane_clk_i && lclk_prev_reg;
  endsequence

  // asynchronous mode
  sequence async_on_s;
    enable_i && async_sel_i;
  endsequence

  // disabled while the lane clock rises
  sequence off_rise_s;
    !enable_i && lclk_rise;
  endsequence

  // =====================================================================
  // disabled behaviour
  // outputs low one cycle after enable drops
  off_forces_low_a: assert property (
    !enable_i |=> lane_out_o == '0)
    else $error("outputs not low while disabled");

  // capture flops frozen while disabled
  off_freezes_held_a: assert property (
    !enable_i |=> $stable(lane_if.held))
    else $error("held data changed while disabled");

  // =====================================================================
  // asynchronous mode
  // output follows the input one cycle later
  async_follow_a: assert property (
    enable_i && async_sel_i |=> lane_out_o == $past(lane_data_i))
    else $error("async output does not follow input");

  // lane clock moves neither the flops nor the pass-through path
  async_no_capture_a: assert property (
    enable_i && async_sel_i ##1 enable_i && async_sel_i
      |-> $stable(lane_if.held) && lane_out_o == $past(lane_data_i))
    else $error("clock affected async lanes");

  // =====================================================================
  // synchronous mode
  // all lanes captured together on a rise
  sync_capture_a: assert property (
    sync_rise_s |=> lane_if.held == $past(lane_data_i)
                    && lane_out_o == $past(lane_data_i))
    else $error("lanes not captured together on rise");

  // a falling lane clock captures nothing
  sync_fall_ignored_a: assert property (
    sync_fall_s |=> $stable(lane_if.held))
    else $error("capture on falling edge");

  // output shows the capture flops
  sync_out_held_a: assert property (
    enable_i && !async_sel_i |=> lane_out_o == lane_if.held)
    else $error("sync output not from capture flop");

  // output steady between rising edges
  sync_hold_a: assert property (
    enable_i && !async_sel_i && !lclk_rise ##1 enable_i && !async_sel_i && !lclk_rise
      |=> lane_out_o == $past(lane_out_o))
    else $error("sync output changed between edges");

  // enabled output on the path that the select picked
  enabled_path_a: assert property (
    enable_i |=> lane_out_o == ($past(async_sel_i) ? $past(lane_data_i)
                                                   : lane_if.held))
    else $error("enabled output not on selected path");

  // =====================================================================
  // strobe gating and mode changes
  // no capture strobe while disabled
  off_no_strobe_a: assert property (
    !enable_i |-> !lane_if.capture)
    else $error("capture strobe while disabled");

  // a select change while disabled leaves outputs low and flops alone
  off_sel_ignored_a: assert property (
    !enable_i && $changed(async_sel_i) |=> lane_out_o == '0 && $stable(lane_if.held))
    else $error("select change acted on while disabled");

  // a rise seen while disabled is not captured once enabled again
  off_rise_dropped_a: assert property (
    off_rise_s ##1 (!enable_i && lane_clk_i) ##1 sync_level_s |=> $stable(lane_if.held))
    else $error("rise from disabled time captured later");

  // no capture strobe in asynchronous mode
  async_no_strobe_a: assert property (
    async_on_s |-> !lane_if.capture)
    else $error("capture strobe in asynchronous mode");

  // a lane clock that stays high is not a second capture event
  sync_level_hold_a: assert property (
    sync_level_s |=> $stable(lane_if.held))
    else $error("capture on a steady high lane clock");

  // without a rising edge the flops keep their value
  sync_quiet_hold_a: assert property (
    sync_quiet_s |=> $stable(lane_if.held))
    else $error("flops changed between rising edges");

  // after a disabled cycle, re-enabling shows the flops from before
  reenable_held_a: assert property (
    !enable_i ##1 sync_quiet_s |=> lane_out_o == $past(lane_if.held, 2))
    else $error("re-enabled output lost the held value");

  // each lane passes its own input in asynchronous mode
  genvar k;
  generate
    for (k = 0; k < `QRB_LANES; k++) begin : g_async_lane
      lane_pass_a: assert property (
        async_on_s |=> lane_out_o[k] == $past(lane_data_i[k]))
        else $error("lane does not follow its own input");
    end
  endgenerate

endmodule // qrb_top

`default_nettype wire

// ==== dv/qrb_upstream.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========
// upstream logic: control levels, lane clock and lane data
module qrb_upstream
  import qrb_pkg::*;
(
  input  wire logic       clk_i,
  output var  logic       enable_o,
  output var  logic       async_sel_o,
  output var  logic       lane_clk_o,
  output var  qrb_lanes_t lane_data_o
);
  // levels change shortly after the rising edge, then hold
  task automatic drive(input logic en, input logic sel, input logic lclk,
                       input qrb_lanes_t d);
    @(posedge clk_i);
    #1;
    enable_o    = en;
    async_sel_o = sel;
    lane_clk_o  = lclk;
    lane_data_o = d;
  endtask

  // quiet levels at time zero
  initial begin
    enable_o    = 1'b0;
    async_sel_o = 1'b1;
    lane_clk_o  = 1'b0;
    lane_data_o = 4'h0;
  end
endmodule // qrb_upstream

`default_nettype wire

// ==== dv/qrb_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========
// bench for the quad retiming buffer
module qrb_bench;
  import qrb_pkg::*;
  logic       clk_i = 1'b0;
  logic       reset_i = 1'b1;
  logic       en, sel, lclk;
  qrb_lanes_t din, dout;
  int         miscompares = 0;
  int         num_checks = 0;

  // 20 MHz clock
  always #25 clk_i = ~clk_i;

  qrb_upstream up (.clk_i(clk_i), .enable_o(en), .async_sel_o(sel),
                   .lane_clk_o(lclk), .lane_data_o(din));
  qrb_top dut (.clk_i(clk_i), .reset_i(reset_i), .enable_i(en),
               .async_sel_i(sel), .lane_clk_i(lclk), .lane_data_i(din),
               .lane_out_o(dout));

  task automatic check(input qrb_lanes_t seen, input qrb_lanes_t exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // drive levels held for two cycles, look at the output just after the clk_i edge that first samples them
  task automatic step(input logic e, input logic s, input logic c,
                      input qrb_lanes_t d, input qrb_lanes_t exp);
    up.drive(e, s, c, d);
    @(posedge clk_i);
    #1;
    check(dout, exp);
  endtask

  task automatic complete_run;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic test_async;
    step(1'b1, 1'b1, 1'b0, 4'h5, 4'h5);
    step(1'b1, 1'b1, 1'b1, 4'ha, 4'ha);
    step(1'b1, 1'b1, 1'b0, 4'h3, 4'h3);
    $display("test async done");
  endtask

  task automatic test_sync;
    step(1'b1, 1'b0, 1'b0, 4'hc, 4'h0);
    step(1'b1, 1'b0, 1'b1, 4'h9, 4'h9);
    step(1'b1, 1'b0, 1'b0, 4'h6, 4'h9);
    step(1'b1, 1'b0, 1'b1, 4'h6, 4'h6);
    $display("test sync done");
  endtask

  task automatic test_disable;
    step(1'b0, 1'b0, 1'b0, 4'hf, 4'h0);
    step(1'b0, 1'b1, 1'b0, 4'h5, 4'h0);
    step(1'b0, 1'b0, 1'b1, 4'h1, 4'h0);
    step(1'b1, 1'b0, 1'b1, 4'h5, 4'h6);
    $display("test disable done");
  endtask

  // async with a steady lane clock, then back to sync keeps the flops
  task automatic test_switch;
    step(1'b1, 1'b1, 1'b1, 4'h2, 4'h2);
    step(1'b1, 1'b0, 1'b1, 4'hb, 4'h6);
    $display("test switch done");
  endtask

  // mid-run reset with the lane clock high: release is not a rise
  task automatic test_reset;
    up.drive(1'b1, 1'b0, 1'b1, 4'hf);
    reset_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    step(1'b1, 1'b0, 1'b1, 4'hf, 4'h0);
    step(1'b1, 1'b0, 1'b0, 4'h3, 4'h0);
    step(1'b1, 1'b0, 1'b1, 4'ha, 4'ha);
    $display("test reset done");
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    test_async();
    test_sync();
    test_disable();
    test_switch();
    test_reset();
    complete_run();
  end

  // watchdog
  initial begin
    #(200 * 50);
    miscompares++;
    complete_run();
  end
endmodule // qrb_bench

`default_nettype wire
